// file: rtl/cal_seq_defines.vh
`ifndef CAL_SEQ_DEFINES_VH
`define CAL_SEQ_DEFINES_VH
// Register byte offsets.
`define REG_CTRL 12'h000
`define REG_TRIG 12'h004
`define REG_LPDLY 12'h008
`define REG_STATUS 12'h00C
`define REG_TRIM_A 12'h010
`define REG_TRIM_B 12'h014
// Control register fields.
`define CTRL_TRIG_SEL 0
`define CTRL_BG_EN 1
`define CTRL_LOW_POWER_BG_ENABLE 2
`define CTRL_LP_SW 3
`define CTRL_FG_OS 4
`define CTRL_BG_OS 5
`define CTRL_SINGLE 6
`define CTRL_SEL_B 7
// Trigger register field.
`define TRIG_SOFT 0
// Status register fields.
`define ST_DONE 0
`define ST_BUSY 1
`define ST_FG_ACT 2
`define ST_SPARE_LO 4
`define ST_SLEEP 6
// Reset values.
`define CTRL_RST 8'h00
`define LPDLY_RST 32'h0010_0010
`define TRIM_RST 12'h800
// Mid-scale output code in two's complement.
`define MID_CODE 12'h000
`endif

// file: rtl/cal_sequencer.v
`timescale 1ns/1ps
`include "cal_seq_defines.vh"
module cal_sequencer
#(
	parameter BANK_CYCLES = 64,
	parameter OS_CYCLES = 256,
	parameter [11:0] FACTORY_TRIM_A = `TRIM_RST,
	parameter [11:0] FACTORY_TRIM_B = `TRIM_RST
)
(
	input wire core_clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire cal_trigger_pin,
	input wire [11:0] sample_a,
	input wire [11:0] sample_b,
	input wire [11:0] sample_c,
	input wire [11:0] os_error_a,
	input wire [11:0] os_error_b,
	output reg [11:0] out_a,
	output reg [11:0] out_b,
	output reg [2:0] core_online,
	output reg [2:0] core_powered,
	output reg [5:0] bank_cal_active,
	output reg [1:0] core_a_input,
	output reg [1:0] core_b_input,
	output reg foreground_done_flag
);
	// Sequencer states.
	localparam S_IDLE = 3'd0;
	localparam S_FG_BANK = 3'd1;
	localparam S_FG_OS = 3'd2;
	localparam S_BG_SLEEP = 3'd3;
	localparam S_BG_WAKE = 3'd4;
	localparam S_BG_BANK = 3'd5;
	localparam S_BG_OS = 3'd6;
	localparam S_BG_SWAP = 3'd7;
	// Reset image of the delay register; both halves reset alike.
	localparam [31:0] LPDLY_INIT = `LPDLY_RST;

	reg [7:0] ctrl_r; // Mode and option bits.
	reg software_cal_trigger_r; // Software trigger bit, a level.
	reg [15:0] spare_sleep_delay_r; // Sleep cycles for the spare core.
	reg [15:0] spare_wake_delay_r; // Stabilisation cycles after wake.
	reg [11:0] trim_a_r; // Input offset trim for input A.
	reg [11:0] trim_b_r; // Input offset trim for input B.
	reg [2:0] state_r;
	reg [15:0] cnt_r; // Counter for the current phase; counts up in bank and offset phases, down in sleep and wake.
	reg [2:0] bank_r; // Bank under calibration, 0 to 5.
	reg [1:0] spare_r; // Core currently out of service.
	reg [1:0] victim_r; // Active core the spare will replace.
	reg trig_d_r; // Previous combined trigger level.
	reg fg_active_r; // Foreground calibration in progress.

	wire wr = psel & penable & pwrite;
	wire trig_sel = ctrl_r[`CTRL_TRIG_SEL];
	wire bg_en = ctrl_r[`CTRL_BG_EN];
	wire low_power_bg_enable = ctrl_r[`CTRL_LOW_POWER_BG_ENABLE];
	wire lp_user = ctrl_r[`CTRL_LP_SW];
	// Select picks the pin when high, the software bit when low.
	wire trig_lvl = trig_sel ? cal_trigger_pin :
		software_cal_trigger_r;
	wire trig_rise = trig_lvl & ~trig_d_r;
	// Offset engine owns the trims while any offset calibration is enabled.
	wire os_busy = ctrl_r[`CTRL_FG_OS] | ctrl_r[`CTRL_BG_OS];

	// The bus never stalls and never reports an error.
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Pick the next core to be replaced. The order C, A, B, C keeps every
	// core in the rotation; always sparing A and B in turn would leave C
	// serving for ever on its power-up calibration.
	function [1:0] next_victim;
		input [1:0] spare;
		begin
			case (spare)
				2'd2: next_victim = 2'd0;
				2'd0: next_victim = 2'd1;
				default: next_victim = 2'd2;
			endcase
		end
	endfunction

	// Read mux; unmapped addresses return zero.
	always @*
	begin
		prdata = 32'h0000_0000;
		case (paddr)
			`REG_CTRL: prdata = {24'h000000, ctrl_r};
			`REG_TRIG: prdata = {31'h0, software_cal_trigger_r};
			`REG_LPDLY: prdata = {spare_wake_delay_r, spare_sleep_delay_r};
			`REG_STATUS: prdata = {25'h0, state_r == S_BG_SLEEP,
				1'b0, spare_r, fg_active_r, state_r != S_IDLE,
				foreground_done_flag};
			`REG_TRIM_A: prdata = {20'h00000, trim_a_r};
			`REG_TRIM_B: prdata = {20'h00000, trim_b_r};
			default: prdata = 32'h0000_0000;
		endcase
	end

	// Register writes; trim writes are dropped while offset cal owns them.
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_r <= `CTRL_RST;
			software_cal_trigger_r <= 1'b0;
			spare_sleep_delay_r <= LPDLY_INIT[15:0];
			spare_wake_delay_r <= LPDLY_INIT[31:16];
		end
		else if (wr)
		begin
			if (paddr == `REG_CTRL)
				ctrl_r <= pwdata[7:0];
			if (paddr == `REG_TRIG)
				software_cal_trigger_r <= pwdata[`TRIG_SOFT];
			if (paddr == `REG_LPDLY)
			begin
				spare_sleep_delay_r <= pwdata[15:0];
				spare_wake_delay_r <= pwdata[31:16];
			end
		end
	end

	// Main calibration sequencer.
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			// Reset lands in bank calibration: power-up calibration.
			state_r <= S_FG_BANK;
			cnt_r <= 16'h0000;
			bank_r <= 3'd0;
			spare_r <= 2'd2;
			victim_r <= 2'd0;
			trig_d_r <= 1'b0;
			fg_active_r <= 1'b1;
			foreground_done_flag <= 1'b0;
			// Per-device factory image, set per build.
			trim_a_r <= FACTORY_TRIM_A;
			trim_b_r <= FACTORY_TRIM_B;
		end
		else
		begin
			trig_d_r <= trig_lvl;
			// Software may adjust trims only when offset cal is off.
			if (wr && !os_busy && paddr == `REG_TRIM_A)
				trim_a_r <= pwdata[11:0];
			if (wr && !os_busy && paddr == `REG_TRIM_B)
				trim_b_r <= pwdata[11:0];
			case (state_r)
				S_IDLE:
				begin
					if (bg_en)
					begin
						// Background entered by its enable bit.
						victim_r <= next_victim(spare_r);
						cnt_r <= spare_sleep_delay_r;
						if (low_power_bg_enable)
							state_r <= S_BG_SLEEP;
						else
						begin
							state_r <= S_BG_BANK;
							cnt_r <= 16'h0000;
						end
						bank_r <= {spare_r, 1'b0};
					end
					else if (trig_rise)
					begin
						// Start foreground; done clears at start.
						state_r <= S_FG_BANK;
						fg_active_r <= 1'b1;
						foreground_done_flag <= 1'b0;
						bank_r <= 3'd0;
						cnt_r <= 16'h0000;
					end
				end
				S_FG_BANK:
				begin
					// Each bank gets a fixed calibration slot.
					if (cnt_r == BANK_CYCLES[15:0] - 16'd1)
					begin
						cnt_r <= 16'h0000;
						if (bank_r == 3'd5)
							state_r <= ctrl_r[`CTRL_FG_OS] ?
								S_FG_OS : S_IDLE;
						else
							bank_r <= bank_r + 3'd1;
						if (bank_r == 3'd5 && !ctrl_r[`CTRL_FG_OS])
						begin
							fg_active_r <= 1'b0;
							foreground_done_flag <= 1'b1;
						end
					end
					else
						cnt_r <= cnt_r + 16'd1;
				end
				S_FG_OS:
				begin
					// One offset pass, results into trims.
					if (cnt_r == OS_CYCLES[15:0] - 16'd1)
					begin
						trim_a_r <= trim_a_r - os_error_a;
						trim_b_r <= trim_b_r - os_error_b;
						fg_active_r <= 1'b0;
						foreground_done_flag <= 1'b1;
						state_r <= S_IDLE;
					end
					else
						cnt_r <= cnt_r + 16'd1;
				end
				S_BG_SLEEP:
				begin
					// Auto mode sleeps; user mode waits for trigger.
					if (!bg_en)
						state_r <= S_IDLE;
					else if (lp_user ? trig_rise : (cnt_r == 16'h0000))
					begin
						state_r <= S_BG_WAKE;
						cnt_r <= spare_wake_delay_r;
					end
					else if (cnt_r != 16'h0000)
						cnt_r <= cnt_r - 16'd1;
				end
				S_BG_WAKE:
				begin
					// Let the woken core settle before calibration.
					if (cnt_r == 16'h0000)
						state_r <= S_BG_BANK;
					else
						cnt_r <= cnt_r - 16'd1;
				end
				S_BG_BANK:
				begin
					// Calibrate both banks of the spare core.
					if (cnt_r == BANK_CYCLES[15:0] - 16'd1)
					begin
						cnt_r <= 16'h0000;
						if (bank_r[0])
							state_r <= ctrl_r[`CTRL_BG_OS] ?
								S_BG_OS : S_BG_SWAP;
						else
							bank_r <= bank_r + 3'd1;
					end
					else
						cnt_r <= cnt_r + 16'd1;
				end
				S_BG_OS:
				begin
					// Offset correction repeated each rotation.
					if (cnt_r == OS_CYCLES[15:0] - 16'd1)
					begin
						trim_a_r <= trim_a_r - os_error_a;
						trim_b_r <= trim_b_r - os_error_b;
						state_r <= S_BG_SWAP;
					end
					else
						cnt_r <= cnt_r + 16'd1;
				end
				S_BG_SWAP:
				begin
					// Spare takes over; displaced core becomes spare.
					spare_r <= victim_r;
					state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// Output path: mid-code in foreground, else online core data.
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			out_a <= `MID_CODE;
			out_b <= `MID_CODE;
		end
		else if (fg_active_r)
		begin
			out_a <= `MID_CODE;
			out_b <= `MID_CODE;
		end
		else
		begin
			// Core C stands in for whichever of A or B is spare.
			out_a <= (spare_r == 2'd0) ? sample_c : sample_a;
			out_b <= (spare_r == 2'd1) ? sample_c : sample_b;
		end
	end

	// Core status, bank activity and input routing.
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			core_online <= 3'b000;
			core_powered <= 3'b111;
			bank_cal_active <= 6'b000000;
			core_a_input <= 2'd0;
			core_b_input <= 2'd1;
		end
		else
		begin
			// Cores offline during foreground; one spare otherwise.
			core_online <= fg_active_r ? 3'b000 :
				~(3'b001 << spare_r);
			// Spare powered down only while sleeping.
			core_powered <= (state_r == S_BG_SLEEP) ?
				~(3'b001 << spare_r) : 3'b111;
			// One bank at a time; banks 2k,2k+1 form core k.
			bank_cal_active <= (state_r == S_FG_BANK ||
				state_r == S_BG_BANK) ? (6'b000001 << bank_r) :
				6'b000000;
			// Dual: A to input A, B to input B; single: both same.
			core_a_input <= ctrl_r[`CTRL_SINGLE] ?
				{1'b0, ctrl_r[`CTRL_SEL_B]} : 2'd0;
			core_b_input <= ctrl_r[`CTRL_SINGLE] ?
				{1'b0, ctrl_r[`CTRL_SEL_B]} : 2'd1;
		end
	end
endmodule // cal_sequencer

// file: verification/cal_seq_monitor.sv
`timescale 1ns/1ps
// Port-level checks on calibration ordering and core power.
module cal_seq_monitor
#(
	parameter BANK_CYCLES = 64,
	parameter OS_CYCLES = 256
)
(
	input wire core_clk,
	input wire rstn,
	input wire [11:0] out_a,
	input wire [11:0] out_b,
	input wire [2:0] core_online,
	input wire [2:0] core_powered,
	input wire [5:0] bank_cal_active,
	input wire foreground_done_flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// High while a foreground run is under way.
	wire fg = !foreground_done_flag;
	// Core k is busy when either of its two banks is.
	wire [2:0] cal = {|bank_cal_active[5:4], |bank_cal_active[3:2],
		|bank_cal_active[1:0]};
	int len_r; // Cycles spent in the current foreground run.
	// A counter bounds the run, since a long repetition would stall tools.
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			len_r <= 0;
		else
			len_r <= fg ? len_r + 1 : 0;
	end
	sequence s_fg; fg && $past(fg); endsequence
	sequence s_bg; !fg && $past(!fg, 2); endsequence
	property p_mid; s_fg |-> out_a == 12'h000 && out_b == 12'h000; endproperty
	a_mid: assert property (p_mid) else $error("Output not mid-code.");
	property p_off; s_fg |-> core_online == 3'b000; endproperty
	a_off: assert property (p_off) else $error("Core online in run.");
	property p_len; $rose(foreground_done_flag) |->
		len_r >= 6 * BANK_CYCLES - 1 &&
		len_r <= 6 * BANK_CYCLES + OS_CYCLES + 2; endproperty
	a_len: assert property (p_len) else $error("Bad run length.");
	property p_one; $onehot0(bank_cal_active); endproperty
	a_one: assert property (p_one) else $error("Two banks at once.");
	property p_spare; (cal & core_online) == 3'b000; endproperty
	a_spare: assert property (p_spare) else $error("Online core busy.");
	property p_keep; s_bg |-> $countones(core_online) >= 2; endproperty
	a_keep: assert property (p_keep) else $error("Data interrupted.");
	property p_pwr; (core_online & ~core_powered) == 3'b000; endproperty
	a_pwr: assert property (p_pwr) else $error("Online core asleep.");
	property p_wake; (cal & ~core_powered) == 3'b000; endproperty
	a_wake: assert property (p_wake) else $error("Asleep in cal.");
endmodule // cal_seq_monitor
bind cal_sequencer cal_seq_monitor #(.BANK_CYCLES(BANK_CYCLES),
	.OS_CYCLES(OS_CYCLES)) mon (.core_clk(core_clk), .rstn(rstn),
	.out_a(out_a), .out_b(out_b), .core_online(core_online),
	.core_powered(core_powered), .bank_cal_active(bank_cal_active),
	.foreground_done_flag(foreground_done_flag));

// file: verification/test_adc_calibration_sequencer.sv
`timescale 1ns/1ps
`include "cal_seq_defines.vh"
// Drives the sequencer over APB and checks it against a register model.
module test_adc_calibration_sequencer;
	localparam B = 4; // Short bank time keeps the run brief.
	localparam OS = 8;
	reg core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pin = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rd;
	reg [11:0] sa = 0, sb = 0, sc = 0, ea = 0, eb = 0;
	wire [31:0] prdata;
	wire [11:0] out_a, out_b;
	wire [2:0] online, powered;
	wire [5:0] bank;
	wire [1:0] ina, inb;
	wire pready, pslverr, done;
	int n_errors = 0, tests_run = 0, cnt, slept, dn;
	int mdl[int]; // Expected register contents by byte offset.
	int ra[5] = '{0, 8, 16, 20, 24};
	logic [31:0] seed = 66459;
	logic [63:0] rv;
	logic [7:0] seen;
	logic [11:0] ea_h, eb_h; // Offset errors the design saw at the last edge.
	logic [2:0] prev_on; // Online set before a user-driven swap.
	logic err; // Error response of the last transfer.
	int c2; // Cycles in which bank 4, the first bank of core C, was under calibration.
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH %0t %h %h", $time, a, e); end end
	cal_sequencer #(.BANK_CYCLES(B), .OS_CYCLES(OS)) DUT (
		.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cal_trigger_pin(pin),
		.sample_a(sa), .sample_b(sb), .sample_c(sc), .os_error_a(ea),
		.os_error_b(eb), .out_a(out_a), .out_b(out_b), .core_online(online),
		.core_powered(powered), .bank_cal_active(bank),
		.core_a_input(ina), .core_b_input(inb),
		.foreground_done_flag(done));
	// Free-running 50 MHz clock.
	initial forever #10 core_clk = ~core_clk;
	function automatic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// New samples every cycle so a stuck output path shows.
	always @(posedge core_clk)
	begin
		rv = {rnd(), rnd()};
		// Keep the values this edge samples, for the offset model.
		{eb_h, ea_h} <= {eb, ea};
		{eb, ea, sc, sb, sa} <= rv[59:0];
	end
	// One APB transfer; trims refuse writes while offset cal is enabled.
	task automatic apb(input bit w, input [11:0] a, input [31:0] d);
		// An idle edge first, so psel is never driven twice in one step.
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk) penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (w && !(a[4] && mdl[0][5:4] != 0))
			mdl[a] = d;
	endtask
	task automatic chk_rd(input [11:0] a);
		logic [32:0] ev;
		ev = {1'b0, 32'(mdl.exists(a) ? mdl[a] : 0)};
		apb(0, a, 0);
		`CHK({err, rd}, ev)
	endtask
	// A fresh rising edge needs the bit cleared first.
	task automatic soft_trig();
		apb(1, `REG_TRIG, 0);
		apb(1, `REG_TRIG, 1);
	endtask
	task automatic wait_done();
		cnt = 0;
		while (done !== 1'b1 && cnt < 500)
		begin
			@(posedge core_clk);
			cnt++;
		end
		`CHK(done, 1'b1)
	endtask
	task automatic print_verdict();
		if (n_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Cuts a hang short well after the expected end.
	initial
	begin
		#100000;
		n_errors++;
		print_verdict();
	end
	initial
	begin
		repeat (5) @(posedge core_clk);
		rstn <= 1;
		wait_done();
		`CHK(cnt >= 6 * B && cnt <= 6 * B + 3, 1'b1)
		mdl[`REG_CTRL] = 0;
		mdl[`REG_LPDLY] = `LPDLY_RST;
		mdl[`REG_TRIM_A] = `TRIM_RST;
		mdl[`REG_TRIM_B] = `TRIM_RST;
		foreach (ra[i]) chk_rd(12'(ra[i]));
		apb(1, `REG_TRIM_A, rv[31:0] & 32'hFFF);
		chk_rd(`REG_TRIM_A);
		apb(1, `REG_CTRL, 32'h10);
		apb(1, `REG_TRIM_B, 32'h123);
		chk_rd(`REG_TRIM_B);
		soft_trig();
		repeat (3) @(posedge core_clk);
		`CHK({done, online, out_a, out_b}, 28'h0)
		`CHK({ina, inb}, 4'b0001)
		wait_done();
		`CHK(cnt >= 6 * B + OS - 4 && cnt <= 6 * B + OS, 1'b1)
		// One offset pass subtracts the error seen at its last edge.
		mdl[`REG_TRIM_A] = (mdl[`REG_TRIM_A] - ea_h) & 32'hFFF;
		mdl[`REG_TRIM_B] = (mdl[`REG_TRIM_B] - eb_h) & 32'hFFF;
		chk_rd(`REG_TRIM_A);
		chk_rd(`REG_TRIM_B);
		apb(1, `REG_CTRL, 32'hC1);
		soft_trig();
		repeat (3) @(posedge core_clk);
		`CHK(done, 1'b1)
		pin <= 1;
		repeat (3) @(posedge core_clk);
		`CHK({done, ina, inb}, 5'b00101)
		pin <= 0;
		wait_done();
		apb(1, `REG_LPDLY, 32'h0004_0004);
		apb(1, `REG_CTRL, 32'h06);
		soft_trig();
		seen = 0;
		slept = 0;
		dn = 1;
		c2 = 0;
		repeat (600)
		begin
			@(posedge core_clk);
			seen[online] = 1;
			slept += (powered !== 3'b111);
			dn &= (done === 1'b1);
			c2 += (bank[4] === 1'b1);
		end
		// Each of the three cores must take its turn as spare.
		`CHK(seen, 8'h68)
		`CHK(dn, 1)
		`CHK(slept > 0, 1'b1)
		// Core C must come back for calibration, not serve for ever.
		`CHK(c2 >= 2 * B, 1'b1)
		// User switching: the spare sleeps until a trigger edge.
		apb(1, `REG_CTRL, 32'h2E);
		repeat (60) @(posedge core_clk);
		`CHK(powered !== 3'b111, 1'b1)
		prev_on = online;
		soft_trig();
		repeat (40) @(posedge core_clk);
		`CHK(online !== prev_on, 1'b1)
		print_verdict();
	end
endmodule // test_adc_calibration_sequencer
